/* pkg/fsrl_defines.svh */
// constants of the flash status register logic
`ifndef FSRL_DEFINES_SVH
`define FSRL_DEFINES_SVH

// opcodes
`define FSRL_OP_READ_STATUS_ONE_CMD 8'h05
`define FSRL_OP_READ_STATUS_TWO_CMD 8'h07
`define FSRL_OP_WRR 8'h01
`define FSRL_OP_SET_WRITE_LATCH_CMD 8'h06
`define FSRL_OP_CLEAR_WRITE_LATCH_CMD 8'h04
`define FSRL_OP_CLEAR_STATUS_CMD 8'h30
`define FSRL_OP_PROG 8'h02
`define FSRL_OP_SERASE 8'hD8
`define FSRL_OP_BERASE 8'hC7
`define FSRL_OP_ERASE_SUSPEND_CMD 8'h75
`define FSRL_OP_PROGRAM_SUSPEND_CMD 8'h85
`define FSRL_OP_SWRST 8'hF0

// status_one and config bit positions
`define FSRL_B_LOCK 7
`define FSRL_B_PERR 6
`define FSRL_B_EERR 5
`define FSRL_B_BPHI 4
`define FSRL_B_BPLO 2
`define FSRL_B_WEL 1
`define FSRL_B_BUSY 0
`define FSRL_CFG_VOLSEL 3

// reset and shipped values
`define FSRL_BP_DEFAULT 3'h7
`define FSRL_BP_SHIP 3'h7
`define FSRL_LOCK_SHIP 1'h0
`define FSRL_CFG_DEFAULT 8'h02

// byte counts of a frame
`define FSRL_BYTES_ONE 3'h1
`define FSRL_BYTES_TWO 3'h2
`define FSRL_BYTES_THREE 3'h3
`define FSRL_BYTES_MAX 3'h4

// timing
`define FSRL_CLK_MHZ 125
`define FSRL_WRR_NS 1000
`define FSRL_WRR_CYC ((`FSRL_WRR_NS * `FSRL_CLK_MHZ + 999) / 1000)
`define FSRL_PUB_HOLD 3'h4

`endif

/* pkg/fsrl_pkg.sv */
// types of the flash status register logic
package fsrl_pkg;
    typedef enum logic [1:0] {
        FSRL_IDLE = 2'h0,
        FSRL_ARRAY = 2'h1,
        FSRL_REGWR = 2'h2
    } fsrl_state_e;
    typedef enum logic [1:0] {
        FSRL_K_PROG = 2'h0,
        FSRL_K_SECT = 2'h1,
        FSRL_K_WHOLE = 2'h2
    } fsrl_kind_e;
endpackage : fsrl_pkg

/* rtl/fsrl_core.sv */
// status register one logic of a serial flash, serial link and command gate
//
// How it works
// R1: 05h reads status; only 01h writes registers
// R2: lock bit plus low pin blocks writes
// R3: hardware protection also locks config bits
// R4: unlocked or pin high lets writes through
// R5: program failure or protection sets program error
// R6: erase failure or blocked sector erase sets erase error
// R7: whole erase ignores protected sector hits
// R8: error flags cleared only by clear-status or reset
// R9: config bit three picks volatile protection
// R10: protection bits refuse covered program/erase
// R11: whole erase only with protection zero
// R12: writes, program, erase need write latch
// R13: 06h sets latch, 04h clears it
// R14: successful operation clears write latch
// R15: host clears status then latch after failure
// R16: resets and finished register writes clear latch
// R17: busy accepts only read, suspend, clear, reset
// R18: suspend only during matching array operation
// R19: error flag keeps busy until clear-status
// R20: busy shows internal operation, read only
// R21: resets restore volatile bits, keep nonvolatile
// R22: writes store only lock and protection bits of status
`include "fsrl_defines.svh"

module fsrl_core
    import fsrl_pkg::*;
(
    // system
    input wire logic clk,
    input wire logic rst_b,
    // serial link
    input wire logic sck,
    input wire logic csB,
    input wire logic si,
    output logic so,
    output logic soOe,
    // pins
    input wire logic wpB,
    input wire logic hwRstB,
    // array engine
    input wire logic targetBlocked,
    input wire logic arrayDone,
    input wire logic arrayFail,
    input wire logic arrayProtHit,
    output logic arrayStart,
    output fsrl_kind_e arrayKind,
    output logic suspendReq,
    // state
    output logic [7:0] statusOne,
    output logic [7:0] configOne,
    output logic [2:0] protectBits,
    output logic hwProtected
);

    // ------------------------------------------------------------
    // link domain: shifting in
    // ------------------------------------------------------------
    logic [2:0] bitIdx;
    logic [2:0] byteNum;
    logic [6:0] shReg;
    logic [7:0] newByte;
    logic [7:0] lnkOp;
    logic [7:0] lnkD1;
    logic [7:0] lnkD2;
    logic [2:0] lnkBytes;
    logic rdActive;
    logic [7:0] outByte;
    logic [2:0] outIdx;
    logic [7:0] pubWord;

    assign newByte = {shReg, si};

    always_ff @(posedge sck or posedge csB) begin
        if (csB) begin
            bitIdx <= 3'h0;
            byteNum <= 3'h0;
        end else begin
            bitIdx <= bitIdx + 3'h1;
            if (bitIdx == 3'h7 && byteNum != `FSRL_BYTES_MAX) begin
                byteNum <= byteNum + 3'h1;
            end
        end
    end

    always_ff @(posedge sck) begin
        shReg <= newByte[6:0];
    end

    // captured words stay put after the frame for the system side
    always_ff @(posedge sck) begin
        if (bitIdx == 3'h7) begin
            case (byteNum)
                3'h0: lnkOp <= newByte;
                3'h1: lnkD1 <= newByte;
                3'h2: lnkD2 <= newByte;
                default: lnkOp <= lnkOp;
            endcase
            lnkBytes <= (byteNum == `FSRL_BYTES_MAX) ? byteNum : byteNum + 3'h1;
        end else if (bitIdx == 3'h0 && byteNum == 3'h0) begin
            lnkBytes <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // link domain: status read out
    // ------------------------------------------------------------
    always_ff @(posedge sck or posedge csB) begin
        if (csB) begin
            rdActive <= 1'b0;
        end else if (bitIdx == 3'h7 && byteNum == 3'h0 && newByte == `FSRL_OP_READ_STATUS_ONE_CMD) begin
            rdActive <= 1'b1; // R1
        end
    end

    // status word stands still while select is low
    always_ff @(posedge sck) begin
        if (bitIdx == 3'h7) begin
            outByte <= pubWord; // R1
        end
    end

    always_ff @(negedge sck or posedge csB) begin
        if (csB) begin
            outIdx <= 3'h7;
            so <= 1'b0;
        end else if (rdActive) begin
            outIdx <= outIdx - 3'h1;
            so <= outByte[outIdx];
        end
    end

    assign soOe = ~csB & rdActive;

    // ------------------------------------------------------------
    // system domain: pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pinRaw;
    logic [2:0] pinS1;
    logic [2:0] pinS2;
    logic csPrev;
    logic frameEnd;
    logic hwRstPrev;

    assign pinRaw = {csB, wpB, hwRstB};

    generate
        for (genvar i = 0; i < 3; i++) begin : g_sync
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    pinS1[i] <= 1'b1;
                    pinS2[i] <= 1'b1;
                end else begin
                    pinS1[i] <= pinRaw[i];
                    pinS2[i] <= pinS1[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            csPrev <= 1'b1;
            hwRstPrev <= 1'b1;
        end else begin
            csPrev <= pinS2[2];
            hwRstPrev <= pinS2[0];
        end
    end

    assign frameEnd = pinS2[2] & ~csPrev;

    // ------------------------------------------------------------
    // system domain: command decode
    // ------------------------------------------------------------
    fsrl_state_e state;
    logic lockBit;
    logic [2:0] protect_volatility_sel;
    logic [2:0] bpVol;
    logic pErr;
    logic eErr;
    logic write_enable_latch;
    logic busy;
    logic volSel;
    logic hwProt;
    logic hasOp;
    logic cmdWrr;
    logic cmdWren;
    logic cmdWrdi;
    logic cmdClsr;
    logic cmdProg;
    logic cmdSect;
    logic cmdWhole;
    logic swRst;
    logic anyRst;
    logic wrrGo;
    logic progGo;
    logic sectGo;
    logic wholeGo;
    logic doneOk;
    logic setPErr;
    logic setEErr;
    logic [7:0] wrCnt;
    logic [7:0] pendStatus;
    logic [7:0] pendCfg;
    logic pendCfgValid;

    assign volSel = configOne[`FSRL_CFG_VOLSEL];
    assign protectBits = volSel ? bpVol : protect_volatility_sel; // R9
    assign hwProt = lockBit & ~pinS2[1]; // R2 R3 R4
    assign hwProtected = hwProt;
    assign busy = (state != FSRL_IDLE) | pErr | eErr; // R19 R20
    assign hasOp = frameEnd && lnkBytes != 3'h0;
    assign swRst = hasOp && lnkOp == `FSRL_OP_SWRST;
    assign anyRst = swRst | (~pinS2[0] & hwRstPrev);

    // while busy only read, suspend, clear and reset get through
    assign cmdWren = hasOp && !busy && lnkOp == `FSRL_OP_SET_WRITE_LATCH_CMD; // R17
    assign cmdWrdi = hasOp && !busy && lnkOp == `FSRL_OP_CLEAR_WRITE_LATCH_CMD; // R17
    assign cmdWrr = hasOp && !busy && lnkOp == `FSRL_OP_WRR
        && (lnkBytes == `FSRL_BYTES_TWO || lnkBytes == `FSRL_BYTES_THREE); // R1 R17
    assign cmdProg = hasOp && !busy && lnkOp == `FSRL_OP_PROG; // R17
    assign cmdSect = hasOp && !busy && lnkOp == `FSRL_OP_SERASE; // R17
    assign cmdWhole = hasOp && !busy && lnkOp == `FSRL_OP_BERASE; // R17
    assign cmdClsr = hasOp && lnkOp == `FSRL_OP_CLEAR_STATUS_CMD;

    assign wrrGo = cmdWrr && write_enable_latch && !hwProt; // R2 R3 R4 R12
    assign progGo = cmdProg && write_enable_latch && !targetBlocked; // R10 R12
    assign sectGo = cmdSect && write_enable_latch && !targetBlocked; // R10 R12
    assign wholeGo = cmdWhole && write_enable_latch && protectBits == 3'h0; // R11 R12

    assign doneOk = state == FSRL_ARRAY && arrayDone && !(setPErr || setEErr);
    assign setPErr = (cmdProg && write_enable_latch && targetBlocked)
        || (state == FSRL_ARRAY && arrayDone && arrayFail && arrayKind == FSRL_K_PROG); // R5
    assign setEErr = (cmdSect && write_enable_latch && targetBlocked)
        || (state == FSRL_ARRAY && arrayDone && arrayFail && arrayKind == FSRL_K_SECT)
        || (state == FSRL_ARRAY && arrayDone && arrayFail && arrayKind == FSRL_K_WHOLE
            && !arrayProtHit); // R6 R7

    // ------------------------------------------------------------
    // system domain: operation sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b || anyRst) begin
            state <= FSRL_IDLE;
            wrCnt <= 8'h00;
        end else begin
            case (state)
                FSRL_IDLE: begin
                    if (wrrGo) begin
                        state <= FSRL_REGWR;
                        wrCnt <= 8'(`FSRL_WRR_CYC - 1);
                    end else if (progGo || sectGo || wholeGo) begin
                        state <= FSRL_ARRAY;
                    end
                end
                FSRL_ARRAY: begin
                    if (arrayDone) begin
                        state <= FSRL_IDLE;
                    end
                end
                FSRL_REGWR: begin
                    if (wrCnt == 8'h00) begin
                        state <= FSRL_IDLE;
                    end else begin
                        wrCnt <= wrCnt - 8'h01;
                    end
                end
                default: state <= FSRL_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            arrayStart <= 1'b0;
            arrayKind <= FSRL_K_PROG;
        end else begin
            arrayStart <= progGo | sectGo | wholeGo;
            if (progGo) begin
                arrayKind <= FSRL_K_PROG;
            end else if (sectGo) begin
                arrayKind <= FSRL_K_SECT;
            end else if (wholeGo) begin
                arrayKind <= FSRL_K_WHOLE;
            end
        end
    end

    // suspend passes only while the matching array job runs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            suspendReq <= 1'b0;
        end else begin
            suspendReq <= hasOp && state == FSRL_ARRAY && ((lnkOp == `FSRL_OP_ERASE_SUSPEND_CMD
                && arrayKind != FSRL_K_PROG) || (lnkOp == `FSRL_OP_PROGRAM_SUSPEND_CMD
                && arrayKind == FSRL_K_PROG)); // R18
        end
    end

    // ------------------------------------------------------------
    // system domain: status bits
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b || anyRst) begin
            write_enable_latch <= 1'b0; // R16 R21
        end else if (cmdWren) begin
            write_enable_latch <= 1'b1; // R13
        end else if (cmdWrdi) begin
            write_enable_latch <= 1'b0; // R13
        end else if (doneOk || (state == FSRL_REGWR && wrCnt == 8'h00)) begin
            write_enable_latch <= 1'b0; // R14
        end
    end

    // set wins over clear
    always_ff @(posedge clk) begin
        if (!rst_b || anyRst) begin
            pErr <= 1'b0;
            eErr <= 1'b0;
        end else begin
            pErr <= setPErr | (pErr & ~cmdClsr); // R5 R8
            eErr <= setEErr | (eErr & ~cmdClsr); // R6 R8
        end
    end

    // only lock and protection bits are kept from the written byte
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pendStatus <= 8'h00;
            pendCfg <= `FSRL_CFG_DEFAULT;
            pendCfgValid <= 1'b0;
        end else if (wrrGo) begin
            pendStatus <= lnkD1; // R22
            pendCfg <= lnkD2;
            pendCfgValid <= lnkBytes == `FSRL_BYTES_THREE;
        end
    end

    // nonvolatile cells survive hardware and software reset
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lockBit <= `FSRL_LOCK_SHIP;
            protect_volatility_sel <= `FSRL_BP_SHIP;
        end else if (state == FSRL_REGWR && wrCnt == 8'h00 && !anyRst) begin
            lockBit <= pendStatus[`FSRL_B_LOCK]; // R22 R21
            if (!volSel) begin
                protect_volatility_sel <= pendStatus[`FSRL_B_BPHI:`FSRL_B_BPLO]; // R9
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || anyRst) begin
            bpVol <= `FSRL_BP_DEFAULT; // R21
            configOne <= `FSRL_CFG_DEFAULT; // R21
        end else if (state == FSRL_REGWR && wrCnt == 8'h00) begin
            if (volSel) begin
                bpVol <= pendStatus[`FSRL_B_BPHI:`FSRL_B_BPLO]; // R9
            end
            if (pendCfgValid) begin
                configOne <= pendCfg; // R3
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            statusOne <= 8'h00;
        end else begin
            statusOne <= {lockBit, pErr, eErr, protectBits, write_enable_latch, busy}; // R20
        end
    end

    // ------------------------------------------------------------
    // system domain: status word toward the link
    // ------------------------------------------------------------
    // follows status only while synced select is high
    // frozen within three clocks of select falling, before the eighth link edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pubWord <= 8'h00;
        end else if (pinS2[2]) begin
            pubWord <= statusOne; // R1
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_wrr_issue;
        hasOp && lnkOp == `FSRL_OP_WRR && !busy && !anyRst;
    endsequence

    a_hwprot_blocks_wrr: assert property (s_wrr_issue ##0 hwProt |=> state != FSRL_REGWR) // R2
        else $error("register write ran under hardware protection");
    a_wrr_needs_wel: assert property (s_wrr_issue ##0 !write_enable_latch |=> state != FSRL_REGWR) // R12
        else $error("register write ran without write latch");
    a_wrr_busy_time: assert property ($rose(state == FSRL_REGWR) |-> busy [*8]) // R20
        else $error("busy dropped early during register write");
    a_busy_gates_set_write_latch_cmd: assert property (hasOp && busy && (lnkOp == `FSRL_OP_SET_WRITE_LATCH_CMD // R17
        || lnkOp == `FSRL_OP_CLEAR_WRITE_LATCH_CMD) && state != FSRL_REGWR && !arrayDone
        && !anyRst |=> $stable(write_enable_latch))
        else $error("latch command taken while busy");
    a_set_write_latch_cmd_sets_wel: assert property (hasOp && !busy && lnkOp == `FSRL_OP_SET_WRITE_LATCH_CMD // R13
        && !anyRst |=> write_enable_latch ##1 statusOne[`FSRL_B_WEL])
        else $error("write enable did not set latch");
    a_reset_clears_wel: assert property (anyRst |=> !write_enable_latch && !pErr && !eErr) // R16
        else $error("reset left latch or errors set");
    a_clear_status_cmd_clears_err: assert property (cmdClsr && !setPErr && !setEErr && !anyRst // R8
        |=> !pErr && !eErr)
        else $error("clear status did not clear errors");
    a_err_keeps_busy: assert property ((pErr || eErr) |-> busy) // R19
        else $error("busy low with error flag set");
    a_done_clears_wel: assert property (doneOk && !cmdWren && !anyRst |=> !write_enable_latch) // R14
        else $error("latch still set after good operation");
    a_whole_needs_zero: assert property (arrayStart && arrayKind == FSRL_K_WHOLE // R11
        |-> $past(protectBits) == 3'h0)
        else $error("whole erase started with protection set");
    a_whole_no_prot_err: assert property (state == FSRL_ARRAY // R7
        && arrayKind == FSRL_K_WHOLE
        && arrayDone && arrayProtHit && !eErr && !anyRst |=> !eErr)
        else $error("whole erase flagged protected sector");
    a_prog_blocked_err: assert property (cmdProg && write_enable_latch && targetBlocked && !anyRst // R5
        |=> pErr && !arrayStart)
        else $error("blocked program not flagged");

endmodule : fsrl_core

/* test/fsrl_host_model.sv */
// host side of the serial link, mode 0 frames
module fsrl_host_model (
    // serial link
    output logic sck,
    output logic csB,
    output logic si,
    input wire logic so,
    input wire logic soOe
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sck = 1'b0;
        csB = 1'b1;
        si = 1'b0;
    end

    // ----------------------------------------
    // one frame: bytes out msb first, optional status byte in
    // ----------------------------------------
    task automatic frame(input logic [23:0] tx, input int nb, input logic rd,
                         output logic [7:0] rx);
        int nBits;
        nBits = 8 * nb + (rd ? 8 : 0);
        rx = 8'h00;
        #1.3;
        csB = 1'b0;
        for (int i = 0; i < nBits; i++) begin
            si = (i < 24) ? tx[23 - i] : ~si;
            #3 sck = 1'b1;
            if (rd && i >= nBits - 8) begin
                rx = {rx[6:0], soOe ? so : 1'bx};
            end
            #3 sck = 1'b0;
        end
        #3 csB = 1'b1;
        si = ~si;
        // select stays high five system clocks between frames
        #40;
    endtask : frame
endmodule : fsrl_host_model

/* test/tb_top.sv */
// self-checking bench of the flash status register logic
`include "fsrl_defines.svh"

module tb_top
    import fsrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic wp;
        logic [7:0] op;
        logic [15:0] data;
        int nb;
        logic [7:0] expSt;
        logic [7:0] expCfg;
    } fsrl_row_s;

    logic clk = 1'b0;
    logic rst_b, sck, csB, si, so, soOe, wpB, hwRstB, targetBlocked;
    logic arrayDone, arrayFail, arrayProtHit, arrayStart, suspendReq, hwProtected;
    fsrl_kind_e arrayKind;
    logic [7:0] statusOne, configOne, rdByte;
    logic [2:0] protectBits;
    int failures = 0, numChecks = 0, starts = 0, suspends = 0, s0;

    fsrl_row_s rows[10] = '{
        '{1'b1, `FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0000, 1, 8'h1E, 8'h02},
        '{1'b1, `FSRL_OP_CLEAR_WRITE_LATCH_CMD, 16'h0000, 1, 8'h1C, 8'h02},
        '{1'b1, `FSRL_OP_WRR, 16'h0000, 2, 8'h1C, 8'h02},
        '{1'b1, `FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0000, 1, 8'h1E, 8'h02},
        '{1'b1, `FSRL_OP_WRR, 16'hFF00, 2, 8'h9C, 8'h02},
        '{1'b1, `FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0000, 1, 8'h9E, 8'h02},
        '{1'b1, `FSRL_OP_WRR, 16'h8042, 3, 8'h80, 8'h42},
        '{1'b0, `FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0000, 1, 8'h82, 8'h42},
        '{1'b0, `FSRL_OP_WRR, 16'h0002, 3, 8'h82, 8'h42},
        '{1'b1, `FSRL_OP_WRR, 16'h0000, 2, 8'h00, 8'h42}
    };

    always #4 clk = ~clk;

    always @(posedge clk) begin
        if (arrayStart === 1'b1) starts++;
        if (suspendReq === 1'b1) suspends++;
    end

    fsrl_core DUT (.clk(clk), .rst_b(rst_b), .sck(sck), .csB(csB), .si(si), .so(so),
        .soOe(soOe), .wpB(wpB), .hwRstB(hwRstB), .targetBlocked(targetBlocked),
        .arrayDone(arrayDone), .arrayFail(arrayFail), .arrayProtHit(arrayProtHit),
        .arrayStart(arrayStart), .arrayKind(arrayKind), .suspendReq(suspendReq),
        .statusOne(statusOne), .configOne(configOne), .protectBits(protectBits),
        .hwProtected(hwProtected));

    fsrl_host_model host (.sck(sck), .csB(csB), .si(si), .so(so), .soOe(soOe));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        numChecks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, e, g);
        end
    endtask : check

    task automatic st(input string name, input logic [7:0] e);
        check(name, e, statusOne);
    endtask : st

    task automatic cmd(input logic [7:0] op, input logic [15:0] d, input int nb);
        host.frame({op, d}, nb, 1'b0, rdByte);
        repeat (8) @(posedge clk);
        #1;
    endtask : cmd

    task automatic idle();
        int n;
        n = 0;
        while (statusOne[0] !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        #1;
        check("busy", 8'h00, {7'h0, statusOne[0]});
    endtask : idle

    task automatic pulse(input logic f, input logic p);
        @(posedge clk);
        #1;
        arrayFail = f;
        arrayProtHit = p;
        arrayDone = 1'b1;
        @(posedge clk);
        #1;
        arrayDone = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : pulse

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #400000;
        failures++;
        tally_and_finish();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        wpB = 1'b1;
        hwRstB = 1'b1;
        targetBlocked = 1'b0;
        arrayDone = 1'b0;
        arrayFail = 1'b0;
        arrayProtHit = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        st("reset status", 8'h1C);
        check("reset config", 8'h02, configOne);
        foreach (rows[i]) begin
            wpB = rows[i].wp;
            cmd(rows[i].op, rows[i].data, rows[i].nb);
            idle();
            host.frame({`FSRL_OP_READ_STATUS_ONE_CMD, 16'h0}, 1, 1'b1, rdByte);
            check("read status", rows[i].expSt, rdByte);
            st("status", rows[i].expSt);
            check("config", rows[i].expCfg, configOne);
            check("protect bits", {5'h0, rows[i].expSt[4:2]}, {5'h0, protectBits});
            check("hw protect", {7'h0, rows[i].expSt[7] & ~rows[i].wp}, {7'h0, hwProtected});
        end
        // program that fails, suspend and busy gating
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        s0 = starts;
        cmd(`FSRL_OP_PROG, 16'h0, 1);
        check("prog start", 8'(s0 + 1), 8'(starts));
        check("prog kind", {6'h0, FSRL_K_PROG}, {6'h0, arrayKind});
        st("prog busy", 8'h03);
        s0 = suspends;
        cmd(`FSRL_OP_ERASE_SUSPEND_CMD, 16'h0, 1);
        cmd(`FSRL_OP_PROGRAM_SUSPEND_CMD, 16'h0, 1);
        check("prog suspend", 8'(s0 + 1), 8'(suspends));
        pulse(1'b1, 1'b0);
        st("prog error", 8'h43);
        cmd(`FSRL_OP_CLEAR_WRITE_LATCH_CMD, 16'h0, 1);
        st("busy ignores", 8'h43);
        cmd(`FSRL_OP_CLEAR_STATUS_CMD, 16'h0, 1);
        st("clear status", 8'h02);
        cmd(`FSRL_OP_CLEAR_WRITE_LATCH_CMD, 16'h0, 1);
        st("latch off", 8'h00);
        // program that succeeds
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        cmd(`FSRL_OP_PROG, 16'h0, 1);
        pulse(1'b0, 1'b0);
        st("prog ok", 8'h00);
        // protected targets, software reset while busy
        targetBlocked = 1'b1;
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        s0 = starts;
        cmd(`FSRL_OP_PROG, 16'h0, 1);
        st("blocked prog", 8'h43);
        check("blocked start", 8'(s0), 8'(starts));
        cmd(`FSRL_OP_SWRST, 16'h0, 1);
        st("sw reset", 8'h00);
        check("sw reset config", 8'h02, configOne);
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        cmd(`FSRL_OP_SERASE, 16'h0, 1);
        st("blocked erase", 8'h23);
        cmd(`FSRL_OP_CLEAR_STATUS_CMD, 16'h0, 1);
        st("erase cleared", 8'h02);
        targetBlocked = 1'b0;
        // whole erase refused with protection, then run
        cmd(`FSRL_OP_WRR, 16'h0400, 2);
        idle();
        st("bp set", 8'h04);
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        s0 = starts;
        cmd(`FSRL_OP_BERASE, 16'h0, 1);
        st("bulk refused", 8'h06);
        check("bulk no start", 8'(s0), 8'(starts));
        cmd(`FSRL_OP_WRR, 16'h0000, 2);
        idle();
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        cmd(`FSRL_OP_BERASE, 16'h0, 1);
        check("bulk kind", {6'h0, FSRL_K_WHOLE}, {6'h0, arrayKind});
        s0 = suspends;
        cmd(`FSRL_OP_PROGRAM_SUSPEND_CMD, 16'h0, 1);
        cmd(`FSRL_OP_ERASE_SUSPEND_CMD, 16'h0, 1);
        check("erase suspend", 8'(s0 + 1), 8'(suspends));
        pulse(1'b1, 1'b1);
        check("bulk no error", 8'h00, {7'h0, statusOne[5]});
        // hardware reset pin
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        hwRstB = 1'b0;
        repeat (4) @(posedge clk);
        #1 hwRstB = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        st("hw reset", 8'h00);
        check("hw reset config", 8'h02, configOne);
        // volatile protection selected by the config byte
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        cmd(`FSRL_OP_WRR, 16'h0008, 3);
        idle();
        st("vol default", 8'h1C);
        check("vol config", 8'h08, configOne);
        cmd(`FSRL_OP_SET_WRITE_LATCH_CMD, 16'h0, 1);
        cmd(`FSRL_OP_WRR, 16'h0408, 3);
        idle();
        st("vol bits", 8'h04);
        check("vol protect", 8'h01, {5'h0, protectBits});
        cmd(`FSRL_OP_SWRST, 16'h0, 1);
        st("vol reset", 8'h00);
        tally_and_finish();
    end
endmodule : tb_top
